// ### src/charge_consts.vh
// constants for the lithium-ion charge sequencer
`ifndef CHARGE_CONSTS_VH
`define CHARGE_CONSTS_VH
`define CLK_HZ 50000000
`define INIT_BLANK_MS 400
`define INIT_BLANK_CYC ((`CLK_HZ / 1000) * `INIT_BLANK_MS)
`define TICK_US 1000
`define TICK_CYC ((`CLK_HZ / 1000000) * `TICK_US)
`define HOLDOFF_TICKS 1000
`define MAX_CHARGE_TICKS 10800000
`define PWM_PERIOD 100
`define PWM_MAX_DUTY_PCT 80
`define ST_QUALIFY 3'h0
`define ST_PRECOND 3'h1
`define ST_FAST_CC 3'h2
`define ST_FAST_CV 3'h3
`define ST_FINISHED 3'h4
`define ST_FAULT 3'h5
`define ST_BATT_TEST 3'h6
`define ST_INIT 3'h7
`define TERM_LOW 2'h0
`define TERM_HIGH 2'h1
`define TERM_FLOAT 2'h2
`endif

// ### src/duty_limited_pwm.v
// pulse-width modulator whose high time is capped at a fixed share of each period
`timescale 1ns/1ns
`default_nettype none
`include "charge_consts.vh"
module duty_limited_pwm #(
	parameter PERIOD = `PWM_PERIOD,
	parameter MAX_PCT = `PWM_MAX_DUTY_PCT
) (
	input wire clk_in,
	input wire nrst_in,
	input wire enable_in,
	input wire [7:0] duty_in,
	output wire pwm_out
);
	localparam [7:0] LAST = PERIOD - 1;
	localparam [7:0] CAP = (PERIOD * MAX_PCT) / 100;
	reg [7:0] count_reg;
	reg pwm_reg;
	wire [7:0] duty_lim;

	// clamp the request to the duty ceiling
	assign duty_lim = (duty_in > CAP) ? CAP : duty_in; // R14
	assign pwm_out = pwm_reg;

	// period counter and registered output
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_reg <= 8'h00;
			pwm_reg <= 1'b0;
		end else begin
			count_reg <= (count_reg == LAST) ? 8'h00 : count_reg + 8'h01;
			pwm_reg <= enable_in && (count_reg < duty_lim); // R13 R26
		end
	end
endmodule // duty_limited_pwm
`default_nettype wire

// ### src/liion_charge_sequencer.v
// charge sequencing state machine with status, probe and switch drive outputs
`timescale 1ns/1ns
`default_nettype none
`include "charge_consts.vh"
// Operation
// R1: first fast phase holds constant current until voltage reaches regulation level.
// R2: second phase holds voltage until current below stop level, then finished.
// R3: new cycle starts at power-up with battery or on battery insertion.
// R4: stay in qualify, no charge, until temperature and voltage are valid.
// R5: over-temperature in any charging state goes to finished with no current.
// R6: leave finished only with temperature valid and voltage below recharge level; the code also leaves finished for battery test when s_lco drops.
// R7: under-temperature in any charging state returns to qualify.
// R8: after qualifying, enter precondition at one tenth of fast current.
// R9: ignore voltage comparison for a hold-off interval after entering precondition.
// R10: fault if exit voltage not reached when quarter-of-maximum time expires.
// R11: exit voltage reached in time moves precondition to fast charge.
// R12: fault waits for power cycle or new insertion, then requalifies.
// R13: switch drive is push-pull PWM, high passes current.
// R14: switch drive never high for more than eighty percent of a period.
// R15: battery probe output high whenever no battery is detected.
// R16: open-drain charge active low when absent, temperature wait, fault or done.
// R17: status lights and common return float during initialization.
// R18: three-state termination select chooses full and stop thresholds.
// R19: three-level display select picks one of three display modes.
// R20: sense-side select chooses low-side or high-side sensing.
// R21: capture selects at power-up, blanking lights about 400 ms; termination select is read continuously instead.
// R22: termination low 1/5,1/10; high 1/10,1/15; floating 1/15,1/20.
// R23: battery present only between low and high cutoff voltages.
// R24: comparator inputs pass two synchroniser flops before use.
// R25: hold-off and time limits are counters of one common timebase.
// R26: switch drive held low in every state without charge current.
module liion_charge_sequencer #(
	parameter INIT_CYC = `INIT_BLANK_CYC,
	parameter TICK_CYC = `TICK_CYC,
	parameter HOLDOFF_TICKS = `HOLDOFF_TICKS,
	parameter MAX_TICKS = `MAX_CHARGE_TICKS
) (
	input wire clk_in,
	input wire nrst_in,
	input wire above_regulation_in,
	input wire above_precharge_exit_in,
	input wire below_recharge_in,
	input wire above_low_cutoff_in,
	input wire above_high_cutoff_in,
	input wire below_stop_current_in,
	input wire below_full_current_in,
	input wire temp_hot_in,
	input wire temp_cold_in,
	input wire termination_select_high_in,
	input wire termination_select_low_in,
	input wire display_mode_select_high_in,
	input wire display_mode_select_low_in,
	input wire sense_side_select_in,
	input wire [7:0] regulator_duty_in,
	output wire switch_drive_out,
	output reg [2:0] state_out,
	output reg no_battery_probe_out,
	output reg charge_active_n_oe_out,
	output wire charge_active_n_out,
	output reg status_light_a_out,
	output reg status_light_a_oe_out,
	output reg status_light_b_out,
	output reg status_light_b_oe_out,
	output reg light_common_return_out,
	output reg light_common_return_oe_out,
	output reg [1:0] termination_mode_out,
	output reg [1:0] display_mode_out,
	output reg high_side_sense_out,
	output reg regulate_voltage_out,
	output reg precharge_current_out,
	output reg [4:0] full_divisor_out,
	output reg [4:0] stop_divisor_out,
	output reg full_indicated_out
);
	localparam NSYNC = 14;
	wire [NSYNC-1:0] raw_in;
	wire [NSYNC-1:0] synced;
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [31:0] init_reg;
	reg [31:0] tick_reg;
	reg [31:0] time_reg;
	wire s_reg_v;
	wire s_exit;
	wire s_rchg;
	wire s_lco;
	wire s_hco;
	wire s_stop;
	wire s_full;
	wire s_hot;
	wire s_cold;
	wire s_th;
	wire s_tl;
	wire s_dh;
	wire s_dl;
	wire s_sense;
	wire tick;
	wire present;
	wire temp_ok;
	wire charging;
	wire [31:0] precond_limit;

	// comparator and strap levels as they arrive at the pins
	assign raw_in = {
		above_regulation_in,
		above_precharge_exit_in,
		below_recharge_in,
		above_low_cutoff_in,
		above_high_cutoff_in,
		below_stop_current_in,
		below_full_current_in,
		temp_hot_in,
		temp_cold_in,
		termination_select_high_in,
		termination_select_low_in,
		display_mode_select_high_in,
		display_mode_select_low_in,
		sense_side_select_in
	};
	assign {s_reg_v, s_exit, s_rchg, s_lco, s_hco, s_stop, s_full, s_hot, s_cold,
		s_th, s_tl, s_dh, s_dl, s_sense} = synced;

	// two-flop synchronisers on every comparator and strap level
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			reg meta_reg;
			reg sync_reg;
			always @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= raw_in[gi]; // R24
					sync_reg <= meta_reg;
				end
			end
			// only the second stage leaves the loop
			assign synced[gi] = sync_reg;
		end
	endgenerate

	// derived conditions
	assign present = s_lco && !s_hco; // R23
	assign temp_ok = !s_hot && !s_cold;
	assign tick = (tick_reg == TICK_CYC - 1);
	assign precond_limit = MAX_TICKS / 4; // R10
	assign charging = (state_reg == `ST_PRECOND) || (state_reg == `ST_FAST_CC) ||
		(state_reg == `ST_FAST_CV);

	// next-state logic
	always @* begin
		state_next = state_reg;
		case (state_reg)
			`ST_INIT: begin
				if (init_reg == INIT_CYC - 1)
					state_next = `ST_BATT_TEST; // R21
			end
			`ST_BATT_TEST: begin
				if (present)
					state_next = `ST_QUALIFY; // R3
			end
			`ST_QUALIFY: begin
				if (!present)
					state_next = `ST_BATT_TEST;
				else if (temp_ok)
					state_next = `ST_PRECOND; // R4 R8
			end
			`ST_PRECOND: begin
				// hold-off masks the exit and removal checks
				if (time_reg >= precond_limit)
					state_next = `ST_FAULT; // R10
				else if (time_reg >= HOLDOFF_TICKS && s_exit)
					state_next = `ST_FAST_CC; // R9 R11
				else if (time_reg >= HOLDOFF_TICKS && !present)
					state_next = `ST_BATT_TEST;
			end
			`ST_FAST_CC: begin
				if (!present)
					state_next = `ST_BATT_TEST;
				else if (s_reg_v)
					state_next = `ST_FAST_CV; // R1
				else if (time_reg >= MAX_TICKS)
					state_next = `ST_FINISHED;
			end
			`ST_FAST_CV: begin
				if (!present)
					state_next = `ST_BATT_TEST;
				else if (s_stop || time_reg >= MAX_TICKS)
					state_next = `ST_FINISHED; // R2
			end
			`ST_FINISHED: begin
				if (!s_lco)
					state_next = `ST_BATT_TEST;
				else if (temp_ok && s_rchg)
					state_next = `ST_QUALIFY; // R6
			end
			`ST_FAULT: begin
				// removal or a reset is the only way out of fault
				if (!s_lco)
					state_next = `ST_BATT_TEST; // R12
			end
			default: state_next = `ST_INIT;
		endcase
		// temperature overrides while charging
		if (charging && s_hot)
			state_next = `ST_FINISHED; // R5
		else if (charging && s_cold)
			state_next = `ST_QUALIFY; // R7
	end

	// state, common timebase and phase timer
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= `ST_INIT;
			init_reg <= 32'h0;
			tick_reg <= 32'h0;
			time_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			init_reg <= (state_reg == `ST_INIT) ? init_reg + 32'h1 : 32'h0;
			tick_reg <= tick ? 32'h0 : tick_reg + 32'h1; // R25
			// phase timer restarts on entering precondition and fast charge
			if (state_next == `ST_PRECOND && state_reg != `ST_PRECOND)
				time_reg <= 32'h0;
			else if (state_next == `ST_FAST_CC && state_reg == `ST_PRECOND)
				time_reg <= 32'h0;
			else if (tick)
				time_reg <= time_reg + 32'h1; // R25
		end
	end

	// strap levels latched while the lights float in init
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			display_mode_out <= 2'h2;
			high_side_sense_out <= 1'b0;
		end else if (state_reg == `ST_INIT) begin
			display_mode_out <= s_dl ? 2'h0 : (s_dh ? 2'h1 : 2'h2); // R19 R21
			high_side_sense_out <= s_sense; // R20
		end
	end

	// decoded settings and status outputs
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_out <= `ST_INIT;
			termination_mode_out <= `TERM_FLOAT;
			full_divisor_out <= 5'h0F;
			stop_divisor_out <= 5'h14;
			no_battery_probe_out <= 1'b0;
			charge_active_n_oe_out <= 1'b0;
			status_light_a_out <= 1'b0;
			status_light_a_oe_out <= 1'b0;
			status_light_b_out <= 1'b0;
			status_light_b_oe_out <= 1'b0;
			light_common_return_out <= 1'b0;
			light_common_return_oe_out <= 1'b0;
			regulate_voltage_out <= 1'b0;
			precharge_current_out <= 1'b0;
			full_indicated_out <= 1'b0;
		end else begin
			state_out <= state_reg;
			// termination select read continuously as a three-state level
			if (s_tl) begin
				termination_mode_out <= `TERM_LOW; // R18
				full_divisor_out <= 5'h05; // R22
				stop_divisor_out <= 5'h0A;
			end else if (s_th) begin
				termination_mode_out <= `TERM_HIGH;
				full_divisor_out <= 5'h0A;
				stop_divisor_out <= 5'h0F;
			end else begin
				termination_mode_out <= `TERM_FLOAT;
				full_divisor_out <= 5'h0F;
				stop_divisor_out <= 5'h14;
			end
			no_battery_probe_out <= (state_reg == `ST_BATT_TEST); // R15
			charge_active_n_oe_out <= (state_reg == `ST_BATT_TEST) ||
				(state_reg == `ST_QUALIFY) || (state_reg == `ST_FAULT) ||
				(state_reg == `ST_FINISHED) || (state_reg == `ST_INIT); // R16
			status_light_a_oe_out <= (state_reg != `ST_INIT); // R17
			status_light_b_oe_out <= (state_reg != `ST_INIT);
			light_common_return_oe_out <= (state_reg != `ST_INIT);
			light_common_return_out <= 1'b0;
			full_indicated_out <= (state_reg == `ST_FAST_CV) && s_full;
			status_light_a_out <= charging && !((state_reg == `ST_FAST_CV) && s_full);
			status_light_b_out <= (state_reg == `ST_FINISHED) ||
				(state_reg == `ST_FAULT) ||
				((state_reg == `ST_FAST_CV) && (s_full || (display_mode_out == 2'h2)));
			regulate_voltage_out <= (state_reg == `ST_FAST_CV); // R2
			precharge_current_out <= (state_reg == `ST_PRECOND); // R8
		end
	end

	assign charge_active_n_out = 1'b0;

	// switch drive modulator, off outside charging states
	duty_limited_pwm u_pwm (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.enable_in(charging && !s_hot && !s_cold), // R26
		.duty_in(regulator_duty_in),
		.pwm_out(switch_drive_out)
	);
endmodule // liion_charge_sequencer
`default_nettype wire

// ### test/seq_checker_assertions.sv
// port checker for the charge sequencer
`timescale 1ns/1ns
`default_nettype none
`include "charge_consts.vh"
module seq_checker (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic temp_hot_in,
	input wire logic temp_cold_in,
	input wire logic switch_drive_out,
	input wire logic [2:0] state_out,
	input wire logic no_battery_probe_out,
	input wire logic charge_active_n_oe_out,
	input wire logic status_light_a_oe_out,
	input wire logic status_light_b_oe_out,
	input wire logic light_common_return_oe_out,
	input wire logic [1:0] termination_mode_out,
	input wire logic [4:0] full_divisor_out,
	input wire logic [4:0] stop_divisor_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	logic [7:0] hi_reg;
	logic charge_active_n;
	// length of the current high run on the switch drive
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) hi_reg <= 8'h00;
		else hi_reg <= switch_drive_out ? hi_reg + 8'h01 : 8'h00;
	end
	// states that deliver charge current
	assign charge_active_n = state_out inside {`ST_PRECOND, `ST_FAST_CC, `ST_FAST_CV};
	sequence s_pre_entry;
		$changed(state_out) && state_out == `ST_PRECOND;
	endsequence
	sequence s_temp_ok;
		!temp_hot_in && !temp_cold_in;
	endsequence
	property p_pwm_cap; hi_reg <= 8'h50; endproperty
	property p_idle_low; !charge_active_n && $stable(state_out) |-> !switch_drive_out; endproperty
	property p_probe;
		state_out == `ST_BATT_TEST && $stable(state_out) |-> no_battery_probe_out;
	endproperty
	property p_chg_low;
		state_out inside {`ST_FINISHED, `ST_FAULT, `ST_BATT_TEST} && $stable(state_out)
			|-> charge_active_n_oe_out;
	endproperty
	property p_init_float;
		state_out == `ST_INIT
			|-> !(status_light_a_oe_out || status_light_b_oe_out || light_common_return_oe_out);
	endproperty
	property p_term_low;
		termination_mode_out == `TERM_LOW && $stable(termination_mode_out)
			|-> full_divisor_out == 5'h05 && stop_divisor_out == 5'h0A;
	endproperty
	property p_term_float;
		termination_mode_out == `TERM_FLOAT && $stable(termination_mode_out)
			|-> full_divisor_out == 5'h0F && stop_divisor_out == 5'h14;
	endproperty
	property p_temp_exit; (temp_hot_in || temp_cold_in) [*5] |-> !charge_active_n; endproperty
	property p_pre_hold;
		s_pre_entry and s_temp_ok |=> (state_out != `ST_FAST_CC) [*8];
	endproperty
	property p_pre_bound; s_pre_entry |-> ##[1:60] state_out != `ST_PRECOND; endproperty
	a_pwm_cap: assert property (p_pwm_cap) else $error("switch high too long");
	a_idle_low: assert property (p_idle_low) else $error("switch high when idle");
	a_probe: assert property (p_probe) else $error("probe low in battery test");
	a_chg_low: assert property (p_chg_low) else $error("charge active not low");
	a_init_float: assert property (p_init_float) else $error("lights driven in init");
	a_term_low: assert property (p_term_low) else $error("low select divisors");
	a_term_float: assert property (p_term_float) else $error("float divisors");
	a_temp_exit: assert property (p_temp_exit) else $error("charging out of temp");
	a_pre_hold: assert property (p_pre_hold) else $error("holdoff too short");
	a_pre_bound: assert property (p_pre_bound) else $error("precondition too long");
endmodule // seq_checker
bind liion_charge_sequencer seq_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
	.temp_hot_in(temp_hot_in), .temp_cold_in(temp_cold_in), .switch_drive_out(switch_drive_out),
	.state_out(state_out), .no_battery_probe_out(no_battery_probe_out),
	.charge_active_n_oe_out(charge_active_n_oe_out), .status_light_a_oe_out(status_light_a_oe_out),
	.status_light_b_oe_out(status_light_b_oe_out),
	.light_common_return_oe_out(light_common_return_oe_out),
	.termination_mode_out(termination_mode_out), .full_divisor_out(full_divisor_out),
	.stop_divisor_out(stop_divisor_out));
`default_nettype wire

// ### test/cell_pack_model.sv
// battery pack, thermistor and comparator model
`timescale 1ns/1ns
`default_nettype none
module cell_pack_model (
	input wire logic clk_in,
	input wire logic present_in,
	input wire logic hot_in,
	input wire logic cold_in,
	input wire logic [1:0] level_in,
	input wire logic taper_in,
	output logic [8:0] cmp_out
);
	initial cmp_out = 9'h000;
	// comparators settle one cycle after the pack changes
	always @(posedge clk_in) begin
		cmp_out <= {level_in == 2'h2, level_in != 2'h0, level_in == 2'h0,
			present_in, 1'b0, taper_in, taper_in, hot_in, cold_in};
	end
endmodule // cell_pack_model
`default_nettype wire

// ### test/liion_charge_sequencer_tb_top.sv
// self-checking bench for the charge sequencer
`timescale 1ns/1ns
`default_nettype none
`include "charge_consts.vh"
module liion_charge_sequencer_tb_top;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t got %0h exp %0h", $time, a, b); end end
	logic clk_in = 1'b0, nrst_in = 1'b0, present = 1'b0, hot = 1'b0, cold = 1'b0, taper = 1'b0;
	logic t_hi = 1'b0, t_lo = 1'b1, d_hi = 1'b1, d_lo = 1'b0, current_sense_input = 1'b1;
	logic [1:0] level = 2'h0;
	logic [7:0] duty = 8'h5A;
	logic [8:0] cmp;
	logic sw, probe, chg_oe, a_oe, b_oe, c_oe, hs, reg_v, pre_i, la, lb, lc, chg_n;
	logic [2:0] st;
	logic [1:0] tmode, dmode;
	logic [4:0] fdiv, sdiv;
	int error_cnt = 0, cmp_count = 0;
	always #10 clk_in = ~clk_in;
	cell_pack_model u_pack (.clk_in(clk_in), .present_in(present), .hot_in(hot),
		.cold_in(cold), .level_in(level), .taper_in(taper), .cmp_out(cmp));
	liion_charge_sequencer #(.INIT_CYC(20), .TICK_CYC(4), .HOLDOFF_TICKS(3), .MAX_TICKS(40)) DUT (
		.clk_in(clk_in), .nrst_in(nrst_in), .above_regulation_in(cmp[8]),
		.above_precharge_exit_in(cmp[7]), .below_recharge_in(cmp[6]),
		.above_low_cutoff_in(cmp[5]), .above_high_cutoff_in(cmp[4]),
		.below_stop_current_in(cmp[3]), .below_full_current_in(cmp[2]), .temp_hot_in(cmp[1]),
		.temp_cold_in(cmp[0]), .termination_select_high_in(t_hi), .termination_select_low_in(t_lo),
		.display_mode_select_high_in(d_hi), .display_mode_select_low_in(d_lo),
		.sense_side_select_in(current_sense_input), .regulator_duty_in(duty), .switch_drive_out(sw),
		.state_out(st), .no_battery_probe_out(probe), .charge_active_n_oe_out(chg_oe),
		.charge_active_n_out(chg_n), .status_light_a_out(la), .status_light_a_oe_out(a_oe),
		.status_light_b_out(lb), .status_light_b_oe_out(b_oe), .light_common_return_out(lc),
		.light_common_return_oe_out(c_oe), .termination_mode_out(tmode), .display_mode_out(dmode),
		.high_side_sense_out(hs), .regulate_voltage_out(reg_v), .precharge_current_out(pre_i),
		.full_divisor_out(fdiv), .stop_divisor_out(sdiv), .full_indicated_out());
	// wait for a state under a bounded count
	task automatic wst(input logic [2:0] s);
		int n = 0;
		while (st !== s && n < 200) begin @(negedge clk_in); n++; end
		`CHK(st, s)
	endtask
	task automatic t_init();
		@(negedge clk_in);
		`CHK({st, a_oe, b_oe, c_oe}, {`ST_INIT, 3'h0})
		wst(`ST_BATT_TEST);
		repeat (2) @(negedge clk_in);
		`CHK({probe, chg_oe}, 2'h3)
		`CHK({dmode, hs}, 3'h3)
		`CHK({tmode, fdiv, sdiv}, {`TERM_LOW, 5'h05, 5'h0A})
	endtask
	task automatic t_charge();
		int n = 0;
		@(posedge clk_in); present <= 1'b1; cold <= 1'b1;
		wst(`ST_QUALIFY);
		repeat (30) @(negedge clk_in);
		`CHK({st, sw}, {`ST_QUALIFY, 1'b0})
		@(posedge clk_in); cold <= 1'b0; level <= 2'h1;
		wst(`ST_PRECOND);
		repeat (2) @(negedge clk_in);
		`CHK(pre_i, 1'b1)
		wst(`ST_FAST_CC);
		repeat (3) @(negedge clk_in);
		`CHK({la, lb, chg_n}, 3'h4)
		repeat (100) begin @(negedge clk_in); if (sw === 1'b1) n++; end
		`CHK(n, 80)
		@(posedge clk_in); level <= 2'h2;
		wst(`ST_FAST_CV);
		repeat (2) @(negedge clk_in);
		`CHK(reg_v, 1'b1)
		@(posedge clk_in); taper <= 1'b1;
		wst(`ST_FINISHED);
		`CHK({la, lb, lc, chg_oe}, 4'h5)
	endtask
	task automatic t_hot();
		@(posedge clk_in); present <= 1'b0; taper <= 1'b0; level <= 2'h0;
		wst(`ST_BATT_TEST);
		@(posedge clk_in); present <= 1'b1; level <= 2'h1;
		wst(`ST_FAST_CC);
		@(posedge clk_in); hot <= 1'b1;
		wst(`ST_FINISHED);
		@(posedge clk_in); hot <= 1'b0;
		repeat (20) @(negedge clk_in);
		`CHK({st, sw}, {`ST_FINISHED, 1'b0})
		@(posedge clk_in); level <= 2'h0;
		wst(`ST_PRECOND);
	endtask
	task automatic t_cold();
		@(posedge clk_in); cold <= 1'b1;
		wst(`ST_QUALIFY);
		@(posedge clk_in); cold <= 1'b0;
		wst(`ST_PRECOND);
		wst(`ST_FAULT);
		repeat (20) @(negedge clk_in);
		`CHK({st, chg_oe, sw}, {`ST_FAULT, 2'h2})
		@(posedge clk_in); present <= 1'b0;
		wst(`ST_BATT_TEST);
		@(posedge clk_in); present <= 1'b1;
		wst(`ST_PRECOND);
	endtask
	task automatic t_term();
		@(posedge clk_in); t_hi <= 1'b1; t_lo <= 1'b0;
		repeat (6) @(negedge clk_in);
		`CHK({tmode, fdiv, sdiv}, {`TERM_HIGH, 5'h0A, 5'h0F})
		@(posedge clk_in); t_hi <= 1'b0;
		repeat (6) @(negedge clk_in);
		`CHK({tmode, fdiv, sdiv}, {`TERM_FLOAT, 5'h0F, 5'h14})
	endtask
	// supply cycle with a battery in place and the other strap levels
	task automatic t_power();
		@(posedge clk_in); nrst_in <= 1'b0; d_hi <= 1'b0; d_lo <= 1'b1; current_sense_input <= 1'b0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(negedge clk_in);
		`CHK({st, sw, a_oe}, {`ST_INIT, 2'h0})
		wst(`ST_QUALIFY);
		`CHK({dmode, hs}, 3'h0)
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_init();
		t_charge();
		t_hot();
		t_cold();
		t_term();
		t_power();
		final_report();
	end
	// watchdog well past the expected run
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule // liion_charge_sequencer_tb_top
`default_nettype wire
